// *** logic/lcr_pkg.sv ***
// shared constants for the link control register block
package lcr_pkg;
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] LINK_CONTROL_REG_OFS = 12'h0050;
	localparam int REG_W = 16;
	// field positions
	localparam int ASPM_LSB = 0;
	localparam int ASPM_MSB = 1;
	localparam int RCB_BIT = 3;
	localparam int LINK_DISABLE_BIT_BIT = 4;
	localparam int RETRAIN_BIT = 5;
	localparam int COMMON_REFCLK_FLAG_BIT = 6;
	localparam int EXTENDED_SYNC_BIT_BIT = 7;
	localparam int CLKPM_BIT = 8;
	// reset values and hardwired read values
	localparam logic [1:0] ASPM_RST = 2'h0;
	localparam logic LINK_DISABLE_BIT_RST = 1'b0;
	localparam logic COMMON_REFCLK_FLAG_RST = 1'b0;
	localparam logic EXTENDED_SYNC_BIT_RST = 1'b0;
	localparam logic RCB_VAL = 1'b0;
	localparam logic CLKPM_VAL = 1'b0;
	// power management control encodings
	typedef enum logic [1:0] {
		LCR_ASPM_OFF = 2'b00,
		LCR_ASPM_STANDBY = 2'b01,
		LCR_ASPM_SLEEP = 2'b10,
		LCR_ASPM_BOTH = 2'b11
	} lcr_aspm_t;
endpackage

// *** logic/lcr_retrain_if.sv ***
// carrier between the register bank and the retrain trigger
`timescale 1ns/1ps
`default_nettype none
interface lcr_retrain_if;
	logic wrOne;
	logic allowed;
	logic pulse;
	modport bank (output wrOne, output allowed, input pulse);
	modport trig (input wrOne, input allowed, output pulse);
endinterface
`default_nettype wire

// *** logic/lcr_retrain.sv ***
// one-cycle retrain request toward the training state machine
`timescale 1ns/1ps
`default_nettype none
module lcr_retrain
	import lcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	lcr_retrain_if.trig rt
);
	logic pulse_q;
	logic pulse_d;

	// fires on the same edge that stores the other fields, so they apply to this retrain
	always_comb begin
		pulse_d = rt.wrOne & rt.allowed; // [R6] [R8] [R9] [R10]
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= pulse_d;
		end
	end

	assign rt.pulse = pulse_q;
endmodule
`default_nettype wire

// *** logic/lcr_link_control.sv ***
// link control register bank with apb slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - power management field: 0 off, 1 standby, 2 sleep, 3 both allowed
// R2 - power management field resets to zero; eeprom load may replace it
// R3 - read completion boundary bit reads zero and is read-only
// R4 - downstream port: link disable bit holds the link disabled while set
// R5 - upstream port: link disable bit has no effect on the link
// R6 - writing one to retrain bit sends training machine to recovery
// R7 - retrain bit always reads back zero
// R8 - fields written together with retrain apply to that retraining
// R9 - upstream with unlock clear: retrain reads zero, writes do nothing
// R10 - upstream with unlock set: writing one retrains the upstream link
// R11 - common clock flag is software writable, resets to zero
// R12 - extended sync bit asks for extra ordered sets on exit and recovery
// R13 - clock power management enable reads zero, read-only
// R14 - reserved bits 2 and 15 to 9 read zero, writes ignored
module lcr_link_control
	import lcr_pkg::*;
#(
	parameter bit IS_UPSTREAM = 1'b0
)(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic register_unlock_bit,
	input wire logic eepromLoad,
	input wire logic [1:0] eepromAspm,
	output logic [1:0] aspmCtl,
	output logic linkDisable,
	output logic retrainReq,
	output logic commonClk,
	output logic extSync
);
	lcr_retrain_if rt();

	logic [1:0] aspm_q;
	logic link_disable_bit_q;
	logic common_refclk_flag_q;
	logic extended_sync_bit_q;
	logic linkDis_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic hit;
	logic accWr;
	logic lowLane;
	logic retrainOk;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [REG_W-1:0] readView(
		input logic [1:0] aspm,
		input logic link_disable_bit,
		input logic common_refclk_flag,
		input logic extended_sync_bit
	);
		logic [REG_W-1:0] v;
		v = '0; // [R14]
		v[ASPM_MSB:ASPM_LSB] = aspm;
		v[RCB_BIT] = RCB_VAL; // [R3]
		v[LINK_DISABLE_BIT_BIT] = link_disable_bit;
		v[RETRAIN_BIT] = 1'b0; // [R7] [R9]
		v[COMMON_REFCLK_FLAG_BIT] = common_refclk_flag;
		v[EXTENDED_SYNC_BIT_BIT] = extended_sync_bit;
		v[CLKPM_BIT] = CLKPM_VAL; // [R13]
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb decode

	always_comb begin
		hit = (paddr == LINK_CONTROL_REG_OFS);
		// writes land only at the access edge where pready is sampled high
		accWr = psel & penable & pready_q & pwrite & hit;
		lowLane = pstrb[0];
		// upstream retrain stays locked unless the switch unlock bit is set
		retrainOk = !IS_UPSTREAM || register_unlock_bit; // [R9] [R10]
	end

	// wait state free: answer is ready in the first access cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= psel & ~penable;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= psel & ~penable & ~hit;
		end
	end

	// read data captured in setup; unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite && hit) begin
			prdata_q <= {16'h0000, readView(aspm_q, link_disable_bit_q, common_refclk_flag_q, extended_sync_bit_q)}; // [R7] [R14]
		end else if (psel && !penable) begin
			prdata_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register fields

	// software write wins over an eeprom load in the same cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			aspm_q <= ASPM_RST; // [R2]
		end else if (accWr && lowLane) begin
			aspm_q <= pwdata[ASPM_MSB:ASPM_LSB]; // [R1]
		end else if (eepromLoad) begin
			aspm_q <= eepromAspm; // [R2]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			link_disable_bit_q <= LINK_DISABLE_BIT_RST;
		end else if (accWr && lowLane) begin
			link_disable_bit_q <= pwdata[LINK_DISABLE_BIT_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			common_refclk_flag_q <= COMMON_REFCLK_FLAG_RST; // [R11]
		end else if (accWr && lowLane) begin
			common_refclk_flag_q <= pwdata[COMMON_REFCLK_FLAG_BIT]; // [R11]
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			extended_sync_bit_q <= EXTENDED_SYNC_BIT_RST;
		end else if (accWr && lowLane) begin
			extended_sync_bit_q <= pwdata[EXTENDED_SYNC_BIT_BIT]; // [R12]
		end
	end

	// stored bit stays readable upstream, but never reaches the link there
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			linkDis_q <= 1'b0;
		end else if (accWr && lowLane) begin
			linkDis_q <= pwdata[LINK_DISABLE_BIT_BIT] & !IS_UPSTREAM; // [R4] [R5]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// retrain trigger

	assign rt.wrOne = accWr & lowLane & pwdata[RETRAIN_BIT]; // [R6]
	assign rt.allowed = retrainOk; // [R9] [R10]

	lcr_retrain u_retrain (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.rt(rt)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign aspmCtl = aspm_q;
	assign linkDisable = linkDis_q;
	assign retrainReq = rt.pulse;
	assign commonClk = common_refclk_flag_q;
	assign extSync = extended_sync_bit_q; // [R12]

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	aspm_write_a: assert property (accWr && lowLane |=> aspmCtl == $past(pwdata[1:0])) // [R1]
		else $error("power management field not written");

	aspm_eeprom_a: assert property (eepromLoad && !(accWr && lowLane) |=> aspmCtl == $past(eepromAspm)) // [R2]
		else $error("eeprom value not loaded");

	hardwired_zero_a: assert property (pready |-> !prdata[RCB_BIT] && !prdata[CLKPM_BIT]) // [R3] [R13]
		else $error("hardwired bit reads one");

	reserved_zero_a: assert property (pready |-> prdata[31:9] == '0 && !prdata[2]) // [R14]
		else $error("reserved bits read nonzero");

	retrain_reads_a: assert property (pready |-> !prdata[RETRAIN_BIT]) // [R7]
		else $error("retrain bit reads one");

	link_disable_a: assert property (accWr && lowLane |=> linkDisable == (!IS_UPSTREAM && $past(pwdata[LINK_DISABLE_BIT_BIT]))) // [R4] [R5]
		else $error("link disable output wrong");

	retrain_fire_a: assert property (accWr && lowLane && pwdata[RETRAIN_BIT] && retrainOk |=> retrainReq) // [R6] [R10]
		else $error("retrain not started");

	retrain_lock_a: assert property (!(accWr && lowLane && pwdata[RETRAIN_BIT] && retrainOk) |=> !retrainReq) // [R9]
		else $error("retrain without permitted write");

	retrain_fields_a: assert property (retrainReq |-> commonClk == $past(pwdata[COMMON_REFCLK_FLAG_BIT])
		&& extSync == $past(pwdata[EXTENDED_SYNC_BIT_BIT]) && aspmCtl == $past(pwdata[1:0])) // [R8] [R11] [R12]
		else $error("fields not applied with retrain");

	retrain_one_a: assert property (retrainReq |=> !retrainReq) // [R6]
		else $error("retrain pulse too long");

	////////////////////////////////////////////////////////////////////////
	// apb answer timing

	ready_next_a: assert property (
		psel && !penable
		|=> pready)
		else $error("no answer in first access cycle");

	ready_one_a: assert property (
		pready
		|=> !pready)
		else $error("answer held too long");

	ready_access_a: assert property (
		pready
		|-> psel && penable)
		else $error("answer outside access phase");

	ready_idle_a: assert property (
		!psel
		|=> !pready)
		else $error("answer without a transfer");

	err_ready_a: assert property (
		pslverr
		|-> pready)
		else $error("error without answer");

	err_zero_a: assert property (
		pslverr
		|-> prdata == '0)
		else $error("unmapped read returns data");

	////////////////////////////////////////////////////////////////////////
	// field storage and readback

	aspm_hold_a: assert property ( // [R1] [R2]
		!(accWr && lowLane) && !eepromLoad
		|=> $stable(aspmCtl))
		else $error("power management field changed unasked");

	aspm_read_a: assert property ( // [R1]
		pready && !pwrite && !pslverr && !$past(eepromLoad)
		|-> prdata[ASPM_MSB:ASPM_LSB] == aspmCtl)
		else $error("power management field reads back wrong");

	aspm_wins_a: assert property ( // [R1] [R2]
		accWr && lowLane && eepromLoad
		|=> aspmCtl == $past(pwdata[ASPM_MSB:ASPM_LSB]))
		else $error("eeprom load beat a software write");

	link_disable_bit_hold_a: assert property ( // [R4]
		!(accWr && lowLane)
		|=> $stable(linkDisable))
		else $error("link disable changed without a write");

	link_disable_bit_read_a: assert property ( // [R4]
		!IS_UPSTREAM && pready && !pwrite && !pslverr
		|-> prdata[LINK_DISABLE_BIT_BIT] == linkDisable)
		else $error("link disable readback differs from link");

	link_disable_bit_upstream_a: assert property ( // [R5]
		IS_UPSTREAM
		|-> !linkDisable)
		else $error("upstream link disabled");

	common_refclk_flag_write_a: assert property ( // [R11]
		accWr && lowLane
		|=> commonClk == $past(pwdata[COMMON_REFCLK_FLAG_BIT]))
		else $error("common clock flag not written");

	common_refclk_flag_hold_a: assert property ( // [R11]
		!(accWr && lowLane)
		|=> $stable(commonClk))
		else $error("common clock flag changed without a write");

	common_refclk_flag_read_a: assert property ( // [R11]
		pready && !pwrite && !pslverr
		|-> prdata[COMMON_REFCLK_FLAG_BIT] == commonClk)
		else $error("common clock flag reads back wrong");

	extended_sync_bit_write_a: assert property ( // [R12]
		accWr && lowLane
		|=> extSync == $past(pwdata[EXTENDED_SYNC_BIT_BIT]))
		else $error("extended sync bit not written");

	extended_sync_bit_hold_a: assert property ( // [R12]
		!(accWr && lowLane)
		|=> $stable(extSync))
		else $error("extended sync bit changed without a write");

	extended_sync_bit_read_a: assert property ( // [R12]
		pready && !pwrite && !pslverr
		|-> prdata[EXTENDED_SYNC_BIT_BIT] == extSync)
		else $error("extended sync bit reads back wrong");

	////////////////////////////////////////////////////////////////////////
	// retrain gating

	retrain_locked_a: assert property ( // [R9]
		IS_UPSTREAM && !$past(register_unlock_bit)
		|-> !retrainReq)
		else $error("locked upstream port retrained");

	retrain_up_a: assert property ( // [R10]
		IS_UPSTREAM && register_unlock_bit && accWr && lowLane && pwdata[RETRAIN_BIT]
		|=> retrainReq)
		else $error("unlocked upstream port not retrained");

	retrain_strobe_a: assert property ( // [R6]
		accWr && !lowLane
		|=> !retrainReq)
		else $error("retrain from a write without the low byte");

	write_cov: cover property (accWr && lowLane);
	retrain_cov: cover property (retrainReq);
	unmapped_cov: cover property (pready && pslverr);
	eeprom_cov: cover property (eepromLoad);
	upstream_retrain_cov: cover property (IS_UPSTREAM && retrainReq);
endmodule
`default_nettype wire

// *** verification/lcr_link_control_tb_top.sv ***
// self-checking bench for the link control register block
`timescale 1ns/1ps
`default_nettype none
module lcr_link_control_tb_top;
	import lcr_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, d;
	logic [3:0] pstrb = '0, s;
	logic register_unlock_bit = 1'b0, eepromLoad = 1'b0;
	logic [1:0] eepromAspm = '0, aspmCtl;
	logic pready, pslverr, linkDisable, retrainReq, commonClk, extSync, ldisUp, rtUp, outPend = 1'b0;
	logic [15:0] model = '0;
	logic [40:0] expQ[$];
	logic [40:0] e;
	logic [7:0] outExp;
	wire logic [7:0] outsNow = {aspmCtl, linkDisable, commonClk, extSync, retrainReq, ldisUp, rtUp};
	int nErrors = 0, totalChecks = 0;
	integer seed = 32'h15d1;
	lcr_link_control dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.register_unlock_bit(register_unlock_bit), .eepromLoad(eepromLoad), .eepromAspm(eepromAspm), .aspmCtl(aspmCtl),
		.linkDisable(linkDisable), .retrainReq(retrainReq), .commonClk(commonClk), .extSync(extSync));
	// upstream copy shares the bus; only its link disable and retrain outputs are watched
	lcr_link_control #(.IS_UPSTREAM(1'b1)) dutUp (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(),
		.pready(), .pslverr(), .register_unlock_bit(register_unlock_bit), .eepromLoad(eepromLoad), .eepromAspm(eepromAspm),
		.aspmCtl(), .linkDisable(ldisUp), .retrainReq(rtUp), .commonClk(), .extSync());
	////////////////////////////////////////////////////////////////
	initial forever #2 ref_clk = ~ref_clk;
	function automatic logic [7:0] expOuts(input logic rd, input logic ru);
		return {model[1:0], model[4], model[6], model[7], rd, 1'b0, ru};
	endfunction
	task automatic cmpRd(input logic [32:0] got, input logic [32:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmpOut(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// apb transfer; psel left high so a following call is back to back
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [3:0] ss,
		input logic u);
		logic hit;
		logic rd;
		hit = (a === LINK_CONTROL_REG_OFS);
		if (w && hit && ss[0]) model = dd[15:0] & 16'h00d3;
		rd = w && hit && ss[0] && dd[5];
		expQ.push_back({!hit, (!w && hit) ? {16'h0, model} : 32'h0, expOuts(rd, rd & u)});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		pstrb <= ss;
		register_unlock_bit <= u;
		@(posedge ref_clk) penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		penable <= 1'b0;
	endtask
	task idle;
		psel <= 1'b0;
		@(posedge ref_clk);
	endtask
	task close_out;
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// monitor: outputs land one cycle after the write edge
	always @(posedge ref_clk) begin
		if (outPend) cmpOut(outsNow, outExp);
		outPend = 1'b0;
		if (psel && penable && pready) begin
			e = expQ.pop_front();
			cmpRd({pslverr, pwrite ? 32'h0 : prdata}, e[40:8]);
			outPend = pwrite;
			outExp = e[7:0];
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		cmpOut(outsNow, 8'h0);
		apb(1'b0, LINK_CONTROL_REG_OFS, 32'h0, 4'hf, 1'b0);
		idle;
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			d = $random(seed);
			d[1:0] = i[1:0];
			if (i[2]) d[5] = 1'b1;
			s = (i > 12) ? 4'($random(seed)) : 4'hf;
			apb(1'b1, LINK_CONTROL_REG_OFS, d, s, i[3]);
			apb(1'b0, LINK_CONTROL_REG_OFS, 32'h0, 4'hf, i[3]);
			idle;
		end
		$display("test fields done");
		apb(1'b1, 12'h054, 32'hffff_ffff, 4'hf, 1'b1);
		apb(1'b0, 12'h054, 32'h0, 4'hf, 1'b1);
		apb(1'b0, LINK_CONTROL_REG_OFS, 32'h0, 4'hf, 1'b1);
		idle;
		$display("test unmapped done");
		eepromAspm <= 2'h2;
		eepromLoad <= 1'b1;
		@(posedge ref_clk) eepromLoad <= 1'b0;
		model[1:0] = 2'h2;
		@(posedge ref_clk);
		cmpOut(outsNow, expOuts(1'b0, 1'b0));
		apb(1'b0, LINK_CONTROL_REG_OFS, 32'h0, 4'hf, 1'b0);
		idle;
		$display("test eeprom done");
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		model = '0;
		@(posedge ref_clk);
		cmpOut(outsNow, 8'h0);
		apb(1'b0, LINK_CONTROL_REG_OFS, 32'h0, 4'hf, 1'b0);
		idle;
		$display("test rereset done");
		close_out;
	end
	// run needs about 110 cycles
	initial begin
		repeat (2000) @(posedge ref_clk);
		nErrors++;
		close_out;
	end
endmodule
`default_nettype wire
